// file: rtl/adccrc_pkg.sv
package adccrc_pkg;
    // Clock cycles after the conversion-start edge during which the channel level is sampled
    localparam int          SEL_WINDOW_CYCLES = 4;
    localparam int          CNT_W             = 3;
    // Result word width
    localparam int          WORD_W            = 16;
    localparam int          BIT_CNT_W         = 5;
    // Configuration word layout shifted in over the serial configuration input
    localparam int          CFG_W             = 16;
    localparam int          CFG_ADDR_MSB      = 15;
    localparam int          CFG_ADDR_LSB      = 12;
    localparam logic [3:0]  ADDR_FIRST_REF    = 4'h1;
    localparam int          REF_PD_BIT        = 0;
    localparam logic [3:0]  ADDR_SECOND_REF   = 4'h2;
    // Power-up defaults: both references off, half-clock timing
    localparam logic        REF_PD_RESET      = 1'b1;
    localparam logic        REF2_EN_RESET     = 1'b0;
    // Strobe pulse width limit for modes II and IV, in clock cycles
    localparam int          STROBE_MAX_CYCLES = 1;

    typedef enum logic [1:0] {
        ADCCRC_IDLE    = 2'b00,
        ADCCRC_SELECT  = 2'b01,
        ADCCRC_CONVERT = 2'b11,
        ADCCRC_DONE    = 2'b10
    } adccrc_conv_e;

    typedef enum logic [1:0] {
        ADCCRC_H_IDLE  = 2'b00,
        ADCCRC_H_START = 2'b01,
        ADCCRC_H_WAIT  = 2'b11,
        ADCCRC_H_READ  = 2'b10
    } adccrc_host_e;
endpackage

// file: rtl/adccrc_link_if.sv
`timescale 1ns/1ns
interface adccrc_link_if;
    logic conversionStartStrobe;
    logic readStrobe;
    logic serialConfigInput;
    logic channelModeSelect;
    logic serialOutputA;
    logic serialOutputAOe;

    modport device (
        input  conversionStartStrobe,
        input  readStrobe,
        input  serialConfigInput,
        input  channelModeSelect,
        output serialOutputA,
        output serialOutputAOe
    );
    modport host (
        output conversionStartStrobe,
        output readStrobe,
        output serialConfigInput,
        output channelModeSelect,
        input  serialOutputA,
        input  serialOutputAOe
    );
endinterface

// file: rtl/adccrc_device.sv
`timescale 1ns/1ns
// What this block does
// R01: Two-channel mode: steady level picks input pair
// R02: Four-channel mode: host holds config input constant
// R03: Primary reference stays powered down until enabled
// R04: Host enables primary reference via first DAC register
// R05: Secondary reference disabled after power-up
// R06: Half-clock default; result only after conversion
// R07: First result bit follows read strobe falling edge
// R08: Modes II/IV: read strobe high one cycle
// R09: Modes II/IV: conversion strobe high one cycle
// R10: FIFO off: one read strobe per conversion
// R11: Sync start edge, count channel-select window cycles
module adccrc_device
    import adccrc_pkg::*;
#(
    parameter int WORD_WIDTH  = WORD_W,
    parameter int CONV_CYCLES = 16
) (
    // Clock and reset
    input  wire logic                  clk_sys,
    input  wire logic                  reset,
    // Link
    adccrc_link_if.device              link,
    // Converter core side
    input  wire logic [WORD_WIDTH-1:0] sampleData,
    output logic                       inputPairSel,
    output logic                       convBusy,
    output logic                       primaryRefEnable,
    output logic                       secondaryRefEnable,
    output logic                       channelSelectError
);
    // ----------------------------------------
    // Pin synchronisers
    // ----------------------------------------
    logic [1:0] cnvSync_reg, rdSync_reg, cfgSync_reg, modeSync_reg;
    logic [1:0] cnvSync_next, rdSync_next, cfgSync_next, modeSync_next;
    logic       cnvLast_reg, rdLast_reg;
    logic       cnvRise, rdFall, cfgLvl, fourChan;

    always_comb begin
        cnvSync_next  = {cnvSync_reg[0], link.conversionStartStrobe};
        rdSync_next   = {rdSync_reg[0], link.readStrobe};
        cfgSync_next  = {cfgSync_reg[0], link.serialConfigInput};
        modeSync_next = {modeSync_reg[0], link.channelModeSelect};
    end

    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            cnvSync_reg  <= 2'h0;
            rdSync_reg   <= 2'h0;
            cfgSync_reg  <= 2'h0;
            modeSync_reg <= 2'h0;
            cnvLast_reg  <= 1'b0;
            rdLast_reg   <= 1'b0;
        end else begin
            cnvSync_reg  <= cnvSync_next;
            rdSync_reg   <= rdSync_next;
            cfgSync_reg  <= cfgSync_next;
            modeSync_reg <= modeSync_next;
            cnvLast_reg  <= cnvSync_reg[1];
            rdLast_reg   <= rdSync_reg[1];
        end
    end

    assign cnvRise  = cnvSync_reg[1] & ~cnvLast_reg; // R11
    assign rdFall   = ~rdSync_reg[1] & rdLast_reg;
    assign cfgLvl   = cfgSync_reg[1];
    assign fourChan = modeSync_reg[1];

    // ----------------------------------------
    // Conversion sequencing
    // ----------------------------------------
    adccrc_conv_e            state_reg, state_next;
    logic [CNT_W-1:0]        winCnt_reg, winCnt_next;
    logic [7:0]              convCnt_reg, convCnt_next;
    logic                    firstLvl_reg, firstLvl_next;
    logic                    mixed_reg, mixed_next;
    logic                    pair_reg, pair_next;
    logic                    selErr_reg, selErr_next;
    logic [WORD_WIDTH-1:0]   result_reg, result_next;
    logic                    resultValid_reg, resultValid_next;
    logic                    busy_reg, busy_next;

    always_comb begin
        state_next       = state_reg;
        winCnt_next      = winCnt_reg;
        convCnt_next     = convCnt_reg;
        firstLvl_next    = firstLvl_reg;
        mixed_next       = mixed_reg;
        pair_next        = pair_reg;
        selErr_next      = selErr_reg;
        result_next      = result_reg;
        resultValid_next = resultValid_reg;
        // Clear first so a result published in the cycle of a read fall is not lost
        if (rdFall) begin
            resultValid_next = 1'b0; // R10
        end
        unique case (state_reg)
            ADCCRC_IDLE: begin
                if (cnvRise) begin // R11
                    state_next    = ADCCRC_SELECT;
                    winCnt_next   = CNT_W'(1);
                    firstLvl_next = cfgLvl;
                    mixed_next    = 1'b0;
                end
            end
            ADCCRC_SELECT: begin
                // Level must stay steady over the whole window or the pair is left unchanged
                if (cfgLvl != firstLvl_reg) begin
                    mixed_next = 1'b1;
                end
                if (winCnt_reg == CNT_W'(SEL_WINDOW_CYCLES)) begin // R11
                    state_next   = ADCCRC_CONVERT;
                    convCnt_next = 8'h00;
                    if (!fourChan) begin
                        if (!(mixed_reg || cfgLvl != firstLvl_reg)) begin
                            pair_next = firstLvl_reg; // R01
                        end
                        selErr_next = mixed_reg || (cfgLvl != firstLvl_reg);
                    end
                end else begin
                    winCnt_next = winCnt_reg + CNT_W'(1);
                end
            end
            ADCCRC_CONVERT: begin
                convCnt_next = convCnt_reg + 8'h01;
                if (convCnt_reg == 8'(CONV_CYCLES - 1)) begin
                    state_next = ADCCRC_DONE;
                end
            end
            ADCCRC_DONE: begin
                // Result is published only once the conversion has ended
                result_next      = sampleData; // R06
                resultValid_next = 1'b1;
                state_next       = ADCCRC_IDLE;
            end
        endcase
        busy_next = (state_next != ADCCRC_IDLE);
    end

    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            state_reg       <= ADCCRC_IDLE;
            winCnt_reg      <= '0;
            convCnt_reg     <= 8'h00;
            firstLvl_reg    <= 1'b0;
            mixed_reg       <= 1'b0;
            pair_reg        <= 1'b0;
            selErr_reg      <= 1'b0;
            result_reg      <= '0;
            resultValid_reg <= 1'b0;
            busy_reg        <= 1'b0;
        end else begin
            state_reg       <= state_next;
            winCnt_reg      <= winCnt_next;
            convCnt_reg     <= convCnt_next;
            firstLvl_reg    <= firstLvl_next;
            mixed_reg       <= mixed_next;
            pair_reg        <= pair_next;
            selErr_reg      <= selErr_next;
            result_reg      <= result_next;
            resultValid_reg <= resultValid_next;
            busy_reg        <= busy_next;
        end
    end

    // ----------------------------------------
    // Serial configuration and references
    // ----------------------------------------
    // Words shift in only during the conversion phase in two-channel mode; a held level never
    // completes a word with a valid address, which is why the host keeps the pin static
    logic [CFG_W-1:0]     cfgShift_reg, cfgShift_next;
    logic [BIT_CNT_W-1:0] cfgCnt_reg, cfgCnt_next;
    logic                 refPd_reg, refPd_next;
    logic                 ref2En_reg, ref2En_next;
    logic                 refEn_reg, refEn_next;

    always_comb begin
        cfgShift_next = cfgShift_reg;
        cfgCnt_next   = cfgCnt_reg;
        refPd_next    = refPd_reg;
        ref2En_next   = ref2En_reg;
        if (cnvRise) begin
            cfgCnt_next = '0;
        end else if (state_reg == ADCCRC_CONVERT && !fourChan && cfgCnt_reg < BIT_CNT_W'(CFG_W)) begin
            cfgShift_next = {cfgShift_reg[CFG_W-2:0], cfgLvl};
            cfgCnt_next   = cfgCnt_reg + BIT_CNT_W'(1);
            if (cfgCnt_reg == BIT_CNT_W'(CFG_W - 1)) begin
                if (cfgShift_reg[CFG_ADDR_MSB-1:CFG_ADDR_LSB-1] == ADDR_FIRST_REF) begin
                    refPd_next = cfgLvl; // R03 R04
                end
                if (cfgShift_reg[CFG_ADDR_MSB-1:CFG_ADDR_LSB-1] == ADDR_SECOND_REF) begin
                    ref2En_next = ~cfgLvl; // R05
                end
            end
        end
        refEn_next = ~refPd_next;
    end

    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            cfgShift_reg <= '0;
            cfgCnt_reg   <= BIT_CNT_W'(CFG_W);
            refPd_reg    <= REF_PD_RESET; // R03
            ref2En_reg   <= REF2_EN_RESET; // R05
            refEn_reg    <= ~REF_PD_RESET; // R03
        end else begin
            cfgShift_reg <= cfgShift_next;
            cfgCnt_reg   <= cfgCnt_next;
            refPd_reg    <= refPd_next;
            ref2En_reg   <= ref2En_next;
            refEn_reg    <= refEn_next;
        end
    end

    // ----------------------------------------
    // Serial output
    // ----------------------------------------
    logic [WORD_WIDTH-1:0] outShift_reg, outShift_next;
    logic [BIT_CNT_W-1:0]  outCnt_reg, outCnt_next;
    logic                  sdo_reg, sdo_next;
    logic                  sdoOe_reg, sdoOe_next;

    always_comb begin
        outShift_next = outShift_reg;
        outCnt_next   = outCnt_reg;
        sdo_next      = sdo_reg;
        sdoOe_next    = sdoOe_reg;
        if (rdFall && resultValid_reg) begin
            sdo_next      = result_reg[WORD_WIDTH-1]; // R07
            outShift_next = {result_reg[WORD_WIDTH-2:0], 1'b0};
            outCnt_next   = BIT_CNT_W'(WORD_WIDTH - 1);
            sdoOe_next    = 1'b1;
        end else if (outCnt_reg != '0) begin
            sdo_next      = outShift_reg[WORD_WIDTH-1];
            outShift_next = {outShift_reg[WORD_WIDTH-2:0], 1'b0};
            outCnt_next   = outCnt_reg - BIT_CNT_W'(1);
        end else begin
            sdoOe_next = 1'b0;
        end
    end

    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            outShift_reg <= '0;
            outCnt_reg   <= '0;
            sdo_reg      <= 1'b0;
            sdoOe_reg    <= 1'b0;
        end else begin
            outShift_reg <= outShift_next;
            outCnt_reg   <= outCnt_next;
            sdo_reg      <= sdo_next;
            sdoOe_reg    <= sdoOe_next;
        end
    end

    assign link.serialOutputA   = sdo_reg;
    assign link.serialOutputAOe = sdoOe_reg;
    assign inputPairSel         = pair_reg;
    assign convBusy             = busy_reg;
    assign primaryRefEnable     = refEn_reg;
    assign secondaryRefEnable   = ref2En_reg;
    assign channelSelectError   = selErr_reg;
endmodule

// file: rtl/adccrc_host.sv
`timescale 1ns/1ns
module adccrc_host
    import adccrc_pkg::*;
#(
    parameter int WORD_WIDTH = WORD_W,
    parameter int WAIT_CYCLES = 32
) (
    // Clock and reset
    input  wire logic                  clk_sys,
    input  wire logic                  reset,
    // Link
    adccrc_link_if.host                link,
    // User side
    input  wire logic                  startReq,
    input  wire logic                  pairReq,
    input  wire logic                  fourChanMode,
    output logic [WORD_WIDTH-1:0]      resultWord,
    output logic                       resultValid,
    output logic                       hostBusy
);
    adccrc_host_e          state_reg, state_next;
    logic [7:0]            cnt_reg, cnt_next;
    logic                  cnv_reg, cnv_next;
    logic                  rd_reg, rd_next;
    logic                  cfg_reg, cfg_next;
    logic                  mode_reg, mode_next;
    logic [WORD_WIDTH-1:0] word_reg, word_next;
    logic                  valid_reg, valid_next;
    logic                  busy_reg, busy_next;
    logic [1:0]            sdoSync_reg, oeSync_reg;

    always_comb begin
        state_next = state_reg;
        cnt_next   = cnt_reg;
        cnv_next   = 1'b0; // R09
        rd_next    = 1'b0; // R08
        cfg_next   = cfg_reg;
        mode_next  = mode_reg;
        word_next  = word_reg;
        valid_next = 1'b0;
        unique case (state_reg)
            ADCCRC_H_IDLE: begin
                if (startReq) begin
                    mode_next  = fourChanMode;
                    // Static level in four-channel mode, pair level otherwise
                    cfg_next   = fourChanMode ? 1'b1 : pairReq; // R02 R01
                    cnv_next   = 1'b1;
                    cnt_next   = 8'h00;
                    state_next = ADCCRC_H_START;
                end
            end
            ADCCRC_H_START: begin
                state_next = ADCCRC_H_WAIT;
            end
            ADCCRC_H_WAIT: begin
                cnt_next = cnt_reg + 8'h01;
                if (cnt_reg == 8'(WAIT_CYCLES)) begin
                    rd_next    = 1'b1; // R10
                    cnt_next   = 8'h00;
                    state_next = ADCCRC_H_READ;
                end
            end
            ADCCRC_H_READ: begin
                cnt_next = cnt_reg + 8'h01;
                if (oeSync_reg[1]) begin
                    word_next = {word_reg[WORD_WIDTH-2:0], sdoSync_reg[1]};
                end
                // Read-fall detect and two sync stages put the last bit five cycles late
                if (cnt_reg == 8'(WORD_WIDTH + 5)) begin
                    valid_next = 1'b1;
                    state_next = ADCCRC_H_IDLE;
                end
            end
        endcase
        busy_next = (state_next != ADCCRC_H_IDLE);
    end

    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            state_reg   <= ADCCRC_H_IDLE;
            cnt_reg     <= 8'h00;
            cnv_reg     <= 1'b0;
            rd_reg      <= 1'b0;
            cfg_reg     <= 1'b1;
            mode_reg    <= 1'b0;
            word_reg    <= '0;
            valid_reg   <= 1'b0;
            busy_reg    <= 1'b0;
            sdoSync_reg <= 2'h0;
            oeSync_reg  <= 2'h0;
        end else begin
            state_reg   <= state_next;
            cnt_reg     <= cnt_next;
            cnv_reg     <= cnv_next;
            rd_reg      <= rd_next;
            cfg_reg     <= cfg_next;
            mode_reg    <= mode_next;
            word_reg    <= word_next;
            valid_reg   <= valid_next;
            busy_reg    <= busy_next;
            sdoSync_reg <= {sdoSync_reg[0], link.serialOutputA};
            oeSync_reg  <= {oeSync_reg[0], link.serialOutputAOe};
        end
    end

    assign link.conversionStartStrobe = cnv_reg;
    assign link.readStrobe            = rd_reg;
    assign link.serialConfigInput     = cfg_reg;
    assign link.channelModeSelect     = mode_reg;
    assign resultWord                 = word_reg;
    assign resultValid                = valid_reg;
    assign hostBusy                   = busy_reg;
endmodule

// file: bench/adccrc_properties.sv
`timescale 1ns/1ns
module adccrc_properties
    import adccrc_pkg::*;
#(
    parameter int CONV_CYCLES = 16
) (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic reset,
    // Link
    input wire logic conversionStartStrobe,
    input wire logic readStrobe,
    input wire logic serialConfigInput,
    input wire logic channelModeSelect,
    input wire logic serialOutputA,
    input wire logic serialOutputAOe
);
    // --------------------------------------------------------------
    // Helper counters
    // --------------------------------------------------------------
    logic       prevStart_reg;
    logic       prevStart_next;
    logic       prevRead_reg;
    logic       prevRead_next;
    logic       pending_reg;
    logic       pending_next;
    logic [7:0] sinceStart_reg;
    logic [7:0] sinceStart_next;
    logic [5:0] oeCnt_reg;
    logic [5:0] oeCnt_next;

    always_comb begin
        prevStart_next  = conversionStartStrobe;
        prevRead_next   = readStrobe;
        pending_next    = pending_reg;
        sinceStart_next = (sinceStart_reg == 8'hFF) ? sinceStart_reg : sinceStart_reg + 8'h01;
        oeCnt_next      = serialOutputAOe ? oeCnt_reg + 6'h01 : 6'h00;
        if (conversionStartStrobe && !prevStart_reg) begin
            pending_next    = 1'b1;
            sinceStart_next = 8'h01;
        end
        if (readStrobe && !prevRead_reg) begin
            pending_next = 1'b0;
        end
    end

    // Saturating start counter so a long idle never wraps into a false pass
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            prevStart_reg  <= 1'b0;
            prevRead_reg   <= 1'b0;
            pending_reg    <= 1'b0;
            sinceStart_reg <= 8'hFF;
            oeCnt_reg      <= 6'h00;
        end else begin
            prevStart_reg  <= prevStart_next;
            prevRead_reg   <= prevRead_next;
            pending_reg    <= pending_next;
            sinceStart_reg <= sinceStart_next;
            oeCnt_reg      <= oeCnt_next;
        end
    end

    // --------------------------------------------------------------
    // Properties
    // --------------------------------------------------------------
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (reset);

    a_start_pulse_width: assert property (
        $rose(conversionStartStrobe) |=> !conversionStartStrobe) else $error("start strobe longer than one cycle");
    a_read_pulse_width: assert property (
        $rose(readStrobe) |=> !readStrobe) else $error("read strobe longer than one cycle");
    a_four_chan_steady: assert property (
        channelModeSelect && $past(channelModeSelect) |-> $stable(serialConfigInput))
        else $error("config input moved in four-channel mode");
    a_first_bit_lag: assert property (
        $fell(readStrobe) |-> ##[1:6] $rose(serialOutputAOe)) else $error("no output after read strobe fall");
    a_word_length: assert property (
        $fell(serialOutputAOe) |-> oeCnt_reg == WORD_W) else $error("output word length wrong");
    a_after_convert: assert property (
        $rose(serialOutputAOe) |-> sinceStart_reg >= SEL_WINDOW_CYCLES + CONV_CYCLES)
        else $error("output started before conversion end");
    a_read_has_conv: assert property (
        $rose(readStrobe) |-> pending_reg) else $error("read strobe without conversion");
    a_one_read_each: assert property (
        $rose(conversionStartStrobe) |-> !pending_reg) else $error("conversion left unread");
    a_quiet_idle: assert property (
        conversionStartStrobe |-> !serialOutputAOe) else $error("output driven during start strobe");
endmodule

// file: bench/adccrc_bench.sv
`timescale 1ns/1ns
module adccrc_bench
    import adccrc_pkg::*;
;
    `define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin mismatches++; \
        $display("Error %0t: got %h expected %h", $time, a, b); end end

    logic              clk_sys;
    logic              reset;
    logic              startReq;
    logic              pairReq;
    logic              fourChanMode;
    logic [WORD_W-1:0] sampleData;
    logic [WORD_W-1:0] resultWord;
    logic              resultValid;
    logic              hostBusy;
    logic              inputPairSel;
    logic              convBusy;
    logic              primaryRefEnable;
    logic              secondaryRefEnable;
    logic              channelSelectError;
    int                mismatches;
    int                n_checks;

    adccrc_link_if link ();

    adccrc_device #(.WORD_WIDTH(WORD_W), .CONV_CYCLES(16)) i_adccrc_device (
        .clk_sys(clk_sys), .reset(reset), .link(link), .sampleData(sampleData),
        .inputPairSel(inputPairSel), .convBusy(convBusy), .primaryRefEnable(primaryRefEnable),
        .secondaryRefEnable(secondaryRefEnable), .channelSelectError(channelSelectError));

    adccrc_host #(.WORD_WIDTH(WORD_W), .WAIT_CYCLES(32)) i_adccrc_host (
        .clk_sys(clk_sys), .reset(reset), .link(link), .startReq(startReq), .pairReq(pairReq),
        .fourChanMode(fourChanMode), .resultWord(resultWord), .resultValid(resultValid), .hostBusy(hostBusy));

    adccrc_properties #(.CONV_CYCLES(16)) i_adccrc_properties (
        .clk_sys(clk_sys), .reset(reset), .conversionStartStrobe(link.conversionStartStrobe),
        .readStrobe(link.readStrobe), .serialConfigInput(link.serialConfigInput),
        .channelModeSelect(link.channelModeSelect), .serialOutputA(link.serialOutputA),
        .serialOutputAOe(link.serialOutputAOe));

    // --------------------------------------------------------------
    // Clock and helpers
    // --------------------------------------------------------------
    initial begin
        clk_sys = 1'b0;
        forever #2 clk_sys = ~clk_sys;
    end

    function automatic logic exp_pair(input logic pair);
        return pair;
    endfunction

    task automatic report_and_stop();
        $display("Checks %0d, mismatches %0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    task automatic wait_idle();
        int k;
        for (k = 0; k < 400 && hostBusy !== 1'b0; k++) begin
            @(posedge clk_sys);
            #1;
        end
        if (k == 400) begin
            mismatches++;
            report_and_stop();
        end
    endtask

    // Entered and left 1 ns after a rising edge
    task automatic run_conv(input logic pair, input logic four, input logic [WORD_W-1:0] data);
        int k;
        pairReq      = pair;
        fourChanMode = four;
        sampleData   = data;
        startReq     = 1'b1;
        @(posedge clk_sys);
        #1;
        startReq = 1'b0;
        for (k = 0; k < 400 && resultValid !== 1'b1; k++) begin
            if (convBusy === 1'b1) `CHK(link.serialOutputAOe, 1'b0)
            @(posedge clk_sys);
            #1;
        end
        if (k == 400) begin
            mismatches++;
            report_and_stop();
        end
        `CHK(resultWord, data)
        if (!four) `CHK(inputPairSel, exp_pair(pair))
        if (!four) `CHK(channelSelectError, 1'b0)
        wait_idle();
    endtask

    task automatic reset_for(input int n);
        reset = 1'b1;
        repeat (n) @(posedge clk_sys);
        #1;
        reset = 1'b0;
        `CHK(primaryRefEnable, 1'b0)
        `CHK(secondaryRefEnable, 1'b0)
        `CHK(link.serialOutputAOe, 1'b0)
    endtask

    // --------------------------------------------------------------
    // Main sequence
    // --------------------------------------------------------------
    initial begin
        mismatches   = 0;
        n_checks     = 0;
        reset        = 1'b1;
        startReq     = 1'b0;
        pairReq      = 1'b0;
        fourChanMode = 1'b0;
        sampleData   = 16'h0000;
        void'($urandom(24));
        reset_for(16);
        // Extreme words and both pairs, back to back
        run_conv(1'b0, 1'b0, 16'h0000);
        run_conv(1'b1, 1'b0, 16'hFFFF);
        run_conv(1'b0, 1'b0, 16'h8001);
        run_conv(1'b1, 1'b1, 16'h5AA5);
        repeat (24) begin
            run_conv(1'($urandom_range(1)), 1'($urandom_range(3) == 0), WORD_W'($urandom));
        end
        // Reset in the middle of a conversion, then resume
        startReq = 1'b1;
        @(posedge clk_sys);
        #1;
        startReq = 1'b0;
        repeat (10) @(posedge clk_sys);
        #1;
        reset_for(3);
        `CHK(hostBusy, 1'b0)
        run_conv(1'b1, 1'b0, 16'hC3C3);
        run_conv(1'b0, 1'b0, 16'h0F0F);
        report_and_stop();
    end
endmodule
